// ==== src/cbt_top.sv ====
/*
 * CAN bit-timing configuration and bit timing engine with Wishbone slave.
 * Assumes rx_i is synchronous to ref_clk and a classic Wishbone master.
 */
// Functional notes
// - Timing registers writable only in configuration mode
// - Phase 2 programmed, else max(phase1, INFORMATION_PROCESSING_TIME)
// - Triple sample: majority of three samples
// - Single sample taken at the sample point
// - Phase 2 field length is value plus one
// - Phase 2 field ignored when source clear
// - Wake-up filter select bypasses or uses filter
// - Unimplemented control C bits read zero
// - Quantum is two times (prescaler plus one)
// - Resync adjustment limited to jump width
`timescale 1ns/1ns
`default_nettype none
module cbt_top
    import cbt_pkg::*;
#(
    parameter int WAKE_CYC = WAKE_FILT_CYC
)(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // CAN receive line and timing outputs
    input  wire logic        rx_i,
    output logic             rx_bit_o,
    output logic             sample_o,
    output logic             bit_start_o,
    output logic             wake_o
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] ctrl_a_ff;
    logic [7:0] ctrl_b_ff;
    logic [7:0] ctrl_c_ff;
    logic       cfg_mode_ff;
    logic       ack_ff;
    logic [31:0] dat_ff;
    logic       req;
    logic       wr_ok;

    assign req   = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wr_ok = req & wb_we_i & wb_sel_i[0];

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cfg_mode_ff <= RST_CFG_MODE;
        end else if (wr_ok && wb_adr_i == ADDR_MODE) begin
            cfg_mode_ff <= wb_dat_i[0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl_a_ff <= RST_CTRL;
            ctrl_b_ff <= RST_CTRL;
            ctrl_c_ff <= RST_CTRL;
        end else if (wr_ok && cfg_mode_ff) begin
            if (wb_adr_i == ADDR_CTRL_A) begin
                ctrl_a_ff <= wb_dat_i[7:0];
            end
            if (wb_adr_i == ADDR_CTRL_B) begin
                ctrl_b_ff <= wb_dat_i[7:0];
            end
            if (wb_adr_i == ADDR_CTRL_C) begin
                ctrl_c_ff <= wb_dat_i[7:0] & C_WR_MASK;
            end
        end
    end

    // ------------------------------------------------------------
    // Segment lengths
    // ------------------------------------------------------------
    logic [3:0] prop_len;
    logic [3:0] ph1_len;
    logic [3:0] ph2_len;
    logic [3:0] sjw_len;
    logic [6:0] tq_div;

    assign prop_len = {1'b0, ctrl_b_ff[2:0]} + 4'h1;
    assign ph1_len  = {1'b0, ctrl_b_ff[5:3]} + 4'h1;
    assign sjw_len  = {2'b00, ctrl_a_ff[7:6]} + 4'h1;
    assign tq_div   = {ctrl_a_ff[5:0], 1'b0} + 7'h2;
    assign ph2_len  = ctrl_b_ff[B_SRC_BIT] ? ({1'b0, ctrl_c_ff[2:0]} + 4'h1) :
                      ((ph1_len > IPT_TQ) ? ph1_len : IPT_TQ);

    // ------------------------------------------------------------
    // Quantum divider
    // ------------------------------------------------------------
    logic [6:0] div_ff;
    logic       tq_en;

    assign tq_en = ~cfg_mode_ff && (div_ff == tq_div - 7'h1);

    always_ff @(posedge ref_clk) begin
        if (srst || cfg_mode_ff || tq_en) begin
            div_ff <= 7'h00;
        end else begin
            div_ff <= div_ff + 7'h01;
        end
    end

    // ------------------------------------------------------------
    // Bit timing engine
    // ------------------------------------------------------------
    cbt_seg_t   seg_ff;
    logic [3:0] cnt_ff;
    logic [3:0] ext_ff;
    logic       edge_ff;
    logic       rx_prev_ff;
    logic       maj;
    logic       ph1_done;
    logic [4:0] ph2_jump;

    assign ph1_done = (cnt_ff == ph1_len + ext_ff);
    assign ph2_jump = {1'b0, cnt_ff} + {1'b0, sjw_len};

    cbt_sampler u_sampler (
        .ref_clk (ref_clk),
        .srst    (srst),
        .tq_en   (tq_en),
        .rx_i    (rx_i),
        .maj_o   (maj)
    );

    // Edge is held until the next quantum so no fall is missed
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rx_prev_ff <= 1'b1;
            edge_ff    <= 1'b0;
        end else begin
            rx_prev_ff <= rx_i;
            if (rx_prev_ff && !rx_i) begin
                edge_ff <= 1'b1;
            end else if (tq_en) begin
                edge_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst || cfg_mode_ff) begin
            seg_ff <= SEG_SYNC;
            cnt_ff <= 4'h1;
            ext_ff <= 4'h0;
        end else if (tq_en) begin
            case (seg_ff)
                SEG_SYNC: begin
                    seg_ff <= SEG_PROP;
                    cnt_ff <= 4'h1;
                    ext_ff <= 4'h0;
                end
                SEG_PROP: begin
                    if (edge_ff) begin
                        ext_ff <= sjw_len;
                    end
                    if (cnt_ff >= prop_len) begin
                        seg_ff <= SEG_PH1;
                        cnt_ff <= 4'h1;
                    end else begin
                        cnt_ff <= cnt_ff + 4'h1;
                    end
                end
                SEG_PH1: begin
                    if (edge_ff && ext_ff == 4'h0) begin
                        ext_ff <= sjw_len;
                    end
                    if (ph1_done) begin
                        seg_ff <= SEG_PH2;
                        cnt_ff <= 4'h1;
                    end else begin
                        cnt_ff <= cnt_ff + 4'h1;
                    end
                end
                SEG_PH2: begin
                    // Shortening by at most the jump width
                    if (cnt_ff >= ph2_len || (edge_ff && ph2_jump >= {1'b0, ph2_len})) begin
                        seg_ff <= SEG_SYNC;
                        cnt_ff <= 4'h1;
                    end else if (edge_ff) begin
                        cnt_ff <= ph2_jump[3:0];
                    end else begin
                        cnt_ff <= cnt_ff + 4'h1;
                    end
                end
                default: begin
                    seg_ff <= SEG_SYNC;
                    cnt_ff <= 4'h1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Sampling outputs
    // ------------------------------------------------------------
    logic sample_now;

    assign sample_now = tq_en && seg_ff == SEG_PH1 && ph1_done;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rx_bit_o    <= 1'b1;
            sample_o    <= 1'b0;
            bit_start_o <= 1'b0;
        end else begin
            sample_o    <= sample_now;
            bit_start_o <= tq_en && seg_ff == SEG_SYNC;
            if (sample_now) begin
                rx_bit_o <= ctrl_b_ff[B_TRIPLE_BIT] ? maj : rx_i;
            end
        end
    end

    // ------------------------------------------------------------
    // Wake-up detection
    // ------------------------------------------------------------
    logic [15:0] low_ff;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            low_ff <= 16'h0000;
            wake_o <= 1'b0;
        end else begin
            low_ff <= rx_i ? 16'h0000 : ((low_ff == 16'hFFFF) ? low_ff : low_ff + 16'h0001);
            if (ctrl_c_ff[C_WAKE_BIT]) begin
                wake_o <= !rx_i && low_ff == 16'(WAKE_CYC - 1);
            end else begin
                wake_o <= rx_prev_ff && !rx_i;
            end
        end
    end

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= req;
            if (req) begin
                case (wb_adr_i)
                    ADDR_CTRL_A: dat_ff <= {24'h000000, ctrl_a_ff};
                    ADDR_CTRL_B: dat_ff <= {24'h000000, ctrl_b_ff};
                    ADDR_CTRL_C: dat_ff <= {24'h000000, ctrl_c_ff & C_WR_MASK};
                    ADDR_MODE:   dat_ff <= {31'h00000000, cfg_mode_ff};
                    ADDR_STATUS: dat_ff <= {27'h0000000, wake_o, rx_bit_o, rx_i, seg_ff};
                    default:     dat_ff <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_locked_write;
        req && wb_we_i && !cfg_mode_ff && wb_adr_i == ADDR_CTRL_B;
    endsequence

    sequence s_sample_single;
        sample_now && !ctrl_b_ff[B_TRIPLE_BIT];
    endsequence

    a_cfg_write_guard: assert property (@(posedge ref_clk) disable iff (srst)
        s_locked_write |=> $stable(ctrl_b_ff)) else $error("timing register changed outside config mode");
    a_res_bits_zero: assert property (@(posedge ref_clk) disable iff (srst)
        (ctrl_c_ff & 8'hB8) == 8'h00) else $error("unimplemented bits not zero");
    a_ph2_derived: assert property (@(posedge ref_clk) disable iff (srst)
        !ctrl_b_ff[B_SRC_BIT] |-> ph2_len >= ph1_len && ph2_len >= IPT_TQ) else $error("derived phase 2 wrong");
    a_single_sample: assert property (@(posedge ref_clk) disable iff (srst)
        s_sample_single |=> rx_bit_o == $past(rx_i) && sample_o) else $error("single sample wrong");
    a_triple_sample: assert property (@(posedge ref_clk) disable iff (srst)
        sample_now && ctrl_b_ff[B_TRIPLE_BIT] |=> rx_bit_o == $past(maj)) else $error("triple sample wrong");
    a_tq_spacing: assert property (@(posedge ref_clk) disable iff (srst)
        tq_en |=> !tq_en) else $error("quantum shorter than two clocks");
    a_sync_one_tq: assert property (@(posedge ref_clk) disable iff (srst || cfg_mode_ff)
        tq_en && seg_ff == SEG_SYNC |=> seg_ff == SEG_PROP && bit_start_o) else $error("sync not one quantum");
    a_prop_bound: assert property (@(posedge ref_clk) disable iff (srst)
        seg_ff == SEG_PROP |-> cnt_ff <= prop_len) else $error("propagation overran");
    a_ext_limit: assert property (@(posedge ref_clk) disable iff (srst)
        ext_ff <= sjw_len) else $error("resync beyond jump width");
endmodule
`default_nettype wire

// ==== pkg/cbt_pkg.sv ====
/*
 * Constants and types for the CAN bit-timing configuration block.
 * Assumes a single 50 MHz reference clock and a 32-bit Wishbone bus.
 */
package cbt_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL_A  = 8'h00;
    localparam logic [7:0] ADDR_CTRL_B  = 8'h04;
    localparam logic [7:0] ADDR_CTRL_C  = 8'h08;
    localparam logic [7:0] ADDR_MODE    = 8'h0C;
    localparam logic [7:0] ADDR_STATUS  = 8'h10;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int         B_SRC_BIT    = 7;
    localparam int         B_TRIPLE_BIT = 6;
    localparam int         C_WAKE_BIT   = 6;
    localparam logic [7:0] C_WR_MASK    = 8'h47;
    localparam logic [7:0] RST_CTRL     = 8'h00;
    localparam logic       RST_CFG_MODE = 1'b1;

    // ------------------------------------------------------------
    // Timing constants
    // ------------------------------------------------------------
    localparam logic [3:0] IPT_TQ        = 4'h2;
    localparam int         WAKE_FILT_NS  = 200;
    localparam int         CLK_PERIOD_NS = 20;
    localparam int         WAKE_FILT_CYC = (WAKE_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        SEG_SYNC = 2'b00,
        SEG_PROP = 2'b01,
        SEG_PH1  = 2'b10,
        SEG_PH2  = 2'b11
    } cbt_seg_t;
endpackage

// ==== src/cbt_sampler.sv ====
/*
 * Three-tap sampler: keeps the bus level at the last three quantum ticks
 * and offers their majority. Assumes rx is synchronous to ref_clk.
 */
`timescale 1ns/1ns
`default_nettype none
module cbt_sampler
    import cbt_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic srst,
    // Sampling
    input  wire logic tq_en,
    input  wire logic rx_i,
    output logic      maj_o
);
    logic [2:0] taps_ff;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            taps_ff <= 3'h7;
        end else if (tq_en) begin
            taps_ff <= {taps_ff[1:0], rx_i};
        end
    end

    // Majority of three filters a single glitchy quantum
    assign maj_o = (taps_ff[0] & taps_ff[1]) | (taps_ff[0] & taps_ff[2]) | (taps_ff[1] & taps_ff[2]);
endmodule
`default_nettype wire

// ==== tb/cbt_node.sv ====
/*
 * Far-side CAN node: drives one byte on the line, MSB first.
 * Assumes the bench ANDs its line with others (wired-AND).
 */
`timescale 1ns/1ns
`default_nettype none
module cbt_node (
    // Clock
    input  wire logic        ref_clk,
    // Frame request
    input  wire logic        go,
    input  wire logic [7:0]  bits,
    input  wire logic [15:0] bit_clk,
    // Line drive, 1 is recessive
    output logic             rx_o,
    output logic             busy_o
);
    logic [7:0]  sh_ff = 8'hFF;
    logic [3:0]  n_ff = 4'h0;
    logic [15:0] c_ff = 16'h0000;

    // Idle line floats to recessive, not to the last bit
    assign busy_o = (n_ff != 4'h0);
    assign rx_o = busy_o ? sh_ff[7] : 1'b1;

    always @(posedge ref_clk) begin
        if (go) begin
            sh_ff <= bits;
            n_ff <= 4'h8;
            c_ff <= 16'h0000;
        end else if (busy_o) begin
            c_ff <= c_ff + 16'h0001;
            if (c_ff == bit_clk - 16'h0001) begin
                c_ff <= 16'h0000;
                n_ff <= n_ff - 4'h1;
                sh_ff <= {sh_ff[6:0], 1'b1};
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/cbt_top_tb.sv ====
/*
 * Bench for cbt_top: registers, bit timing, sampling, wake.
 * Assumes cbt_node shares the line with the bench.
 */
`timescale 1ns/1ns
`default_nettype none
module cbt_top_tb
    import cbt_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'hF;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        ack, rx_bit, smp, bst, wake;
    logic        rx_tb = 1'b1;
    logic        go = 1'b0;
    logic        rx_nd, busy, rx_line;
    logic [7:0]  got = 8'h00;
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          n_wake = 0;

    always #10 ref_clk = ~ref_clk;
    assign rx_line = rx_tb & rx_nd;

    cbt_top #(.WAKE_CYC(3)) i_cbt_top (.ref_clk(ref_clk), .srst(srst),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .rx_i(rx_line), .rx_bit_o(rx_bit), .sample_o(smp),
        .bit_start_o(bst), .wake_o(wake));
    cbt_node i_cbt_node (.ref_clk(ref_clk), .go(go), .bits(8'hA5),
        .bit_clk(16'h0032), .rx_o(rx_nd), .busy_o(busy));

    // Samples outside a frame are idle fill, so skip them
    always @(negedge ref_clk) begin
        if (smp === 1'b1 && busy)
            got = {got[6:0], rx_bit};
        if (wake === 1'b1)
            n_wake++;
    end

    // ------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk_v(input string s, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic chk_n(input string s, input int e, input int g);
        n_checks++;
        if (g != e) begin
            n_mismatch++;
            $display("BAD %s expected %0d seen %0d", s, e, g);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
        @(posedge ref_clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        // No local limit: only the watchdog may end a wait for ack
        do begin
            @(posedge ref_clk);
        end while (ack !== 1'b1);
        q = rdat[7:0];
        cyc <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        wb(1'b0, a, 8'h00, q);
        chk_v("reg", e, q);
    endtask

    task automatic cfg(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
        wr(ADDR_MODE, 8'h01);
        wr(ADDR_CTRL_A, a);
        wr(ADDR_CTRL_B, b);
        wr(ADDR_CTRL_C, c);
        rd(ADDR_CTRL_B, b);
        rd(ADDR_CTRL_C, c & 8'h47);
        wr(ADDR_MODE, 8'h00);
    endtask

    // Clocks from one bit start to its sample and to the next start
    task automatic meas(output int ts, output int tb);
        int k;
        k = 0;
        ts = 0;
        tb = 0;
        do begin
            @(negedge ref_clk);
            k++;
        end while (bst !== 1'b1 && k < 3000);
        do begin
            @(negedge ref_clk);
            tb++;
            if (smp === 1'b1)
                ts = tb;
        end while (bst !== 1'b1 && tb < 3000);
    endtask

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    task automatic low(input int n);
        rx_tb <= 1'b0;
        repeat (n) @(posedge ref_clk);
        rx_tb <= 1'b1;
        repeat (12) @(posedge ref_clk);
    endtask

    initial begin
        logic [7:0] ca [5] = '{8'h00, 8'h03, 8'h3F, 8'hC0, 8'h00};
        logic [7:0] cb [5] = '{8'h91, 8'h00, 8'h00, 8'h38, 8'hBF};
        logic [7:0] cc [5] = '{8'h04, 8'h07, 8'h00, 8'h00, 8'hFF};
        int ts, tb, i, q, pr, p1, p2;
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        rd(ADDR_CTRL_B, 8'h00);
        rd(ADDR_CTRL_C, 8'h00);
        rd(ADDR_MODE, 8'h01);
        rd(ADDR_STATUS, 8'h0C);
        rd(8'h20, 8'h00);
        for (i = 0; i < 5; i++) begin
            cfg(ca[i], cb[i], cc[i]);
            q = 2 * (int'(ca[i][5:0]) + 1);
            pr = int'(cb[i][2:0]) + 1;
            p1 = int'(cb[i][5:3]) + 1;
            p2 = cb[i][7] ? int'(cc[i][2:0]) + 1 : (p1 > int'(IPT_TQ) ? p1 : int'(IPT_TQ));
            meas(ts, tb);
            chk_n("sample_ofs", q * (pr + p1), ts);
            chk_n("bit_len", q * (1 + pr + p1 + p2), tb);
        end
        // Outside configuration mode writes must not land
        wr(ADDR_CTRL_B, 8'h12);
        rd(ADDR_CTRL_B, 8'hBF);
        wr(ADDR_CTRL_C, 8'h00);
        rd(ADDR_CTRL_C, 8'h47);
        for (i = 0; i < 2; i++) begin
            cfg(8'h00, i == 0 ? 8'h3F : 8'h7F, 8'h00);
            go <= 1'b1;
            @(posedge ref_clk);
            go <= 1'b0;
            repeat (460) @(posedge ref_clk);
            if (i == 0)
                chk_v("rx_single", 8'hA5, got);
            else
                chk_v("rx_triple", 8'hA5, got);
        end
        cfg(8'h00, 8'h00, 8'h40);
        n_wake = 0;
        low(2);
        chk_n("wake_short", 0, n_wake);
        low(6);
        chk_n("wake_long", 1, n_wake);
        cfg(8'h00, 8'h00, 8'h00);
        n_wake = 0;
        low(1);
        chk_n("wake_raw", 1, n_wake);
        report_and_stop();
    end

    initial begin
        repeat (40000) @(posedge ref_clk);
        n_mismatch++;
        report_and_stop();
    end
endmodule
`default_nettype wire
